// *** eca_pkg.sv ***
// Package: constants and carriers for the constant-mode address wrapper
package eca_pkg;
    // Address and data widths of the memory port
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    // Wrap window: 64 bytes, six low address bits
    localparam int WRAP_BITS = 6;
    localparam logic [CNT_W-1:0] WRAP_BYTES = 16'h0040;
    // Bytes moved per data beat
    localparam logic [CNT_W-1:0] BEAT_BYTES = 16'h0004;
    localparam logic [ADDR_W-1:0] BEAT_STEP = 32'h0000_0004;
    // FIFO shape on the write data path
    localparam int FIFO_DEPTH = 8;
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CUR = 8'h10;
    localparam logic [7:0] REG_WDATA = 8'h14;
    localparam logic [7:0] REG_RDATA = 8'h18;
    // Control field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_REV2 = 3;
    // Status field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_WRAPPED = 2;
    localparam int STAT_BADREAD = 3;
    // Reset values
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

    // Memory-port access carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic we;
        logic [DATA_W-1:0] data;
    } eca_mem_req_t;

    // Burst states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
    } eca_state_t;
endpackage

// *** eca_fifo.sv ***
// Small flip-flop FIFO for the write data path
`timescale 1ns/1ps
module eca_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];  // Flip-flop storage
    logic [AW-1:0] wr_ptr;          // Next slot to fill
    logic [AW-1:0] rd_ptr;          // Next slot to drain
    logic [AW:0] count;             // Words held
    wire push = in_valid_i && in_ready_o && ce_i;
    wire pop = out_valid_o && out_ready_i && ce_i;

    // Full and empty come straight from the count
    // Compare at the count's own width so a power-of-two depth is not lost
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    // Pointers and count
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Data write, no reset needed on storage
    always_ff @(posedge ref_clk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end
endmodule

// *** eca_port.sv ***
// External memory port address generator with constant-mode wrap
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module eca_port
    import eca_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [eca_pkg::DATA_W-1:0] wb_dat_i,
    output logic [eca_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // External memory side
    output eca_pkg::eca_mem_req_t mem_req_o,
    output logic mem_strobe_o,
    input wire logic mem_ready_i,
    input wire logic [eca_pkg::DATA_W-1:0] mem_rdata_i
);
    import eca_pkg::*;

    // What this block does
    // - Constant-mode writes wrap in 64-byte window
    // - Rev 2.0 constant reads wrap likewise
    // - Count below 64 falls back to stepping
    // - Stepping and single accesses addressed plainly

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic dir_wr;                  // 1 = write burst, 0 = read burst
    logic const_mode;              // Constant (fixed) address mode
    logic rev2;                    // Revision 2.0 read behaviour
    logic [ADDR_W-1:0] base_addr;  // Programmed start address
    logic [CNT_W-1:0] total;       // First-dimension byte count
    logic [ADDR_W-1:0] cur_addr;   // Address of the current beat
    logic [CNT_W-1:0] left;        // Bytes still to move
    logic done;                    // Burst finished, sticky
    logic wrapped;                 // A wrap occurred this burst
    logic bad_read;                // Rev 1.1 constant read happened
    logic [DATA_W-1:0] rdata;      // Last word read from memory
    logic ack;                     // Wishbone acknowledge
    eca_state_t state;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i && !ack;
    wire bus_wr = bus_req && wb_we_i && ce_i;
    wire wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL);
    wire wr_addr = bus_wr && (wb_adr_i == REG_ADDR);
    wire wr_count = bus_wr && (wb_adr_i == REG_COUNT);
    wire wr_data = bus_wr && (wb_adr_i == REG_WDATA);
    wire start = wr_ctrl && wb_dat_i[CTRL_START] && (state != ST_RUN);

    // Merge write data under byte enables
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
            input logic [DATA_W-1:0] n, input logic [3:0] s);
        logic [DATA_W-1:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // Write data FIFO (back-pressure via ack)
    // ----------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic beat;

    eca_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(wr_data),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wb_dat_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(beat && dir_wr),
        .out_data_o(fifo_out_data)
    );

    // ----------------------------------------
    // Address generation
    // ----------------------------------------
    // Wrapping applies only in constant mode with a count of 64 or more;
    // reads wrap only on the later revision.
    wire wrap_ok = const_mode && (total >= WRAP_BYTES)
                   && (dir_wr || rev2);
    wire [WRAP_BITS-1:0] low_next = cur_addr[WRAP_BITS-1:0]
                   + BEAT_STEP[WRAP_BITS-1:0];
    wire [WRAP_BITS-1:0] low_start = base_addr[WRAP_BITS-1:0];
    // Window offset of next beat; crossing 64 bytes returns to start
    wire [WRAP_BITS-1:0] off_next = low_next - low_start;
    wire wrap_now = wrap_ok && (off_next == '0);
    // Upper bits frozen, low six stepped, a 64-byte pass reloads start
    wire [ADDR_W-1:0] wrap_addr = {cur_addr[ADDR_W-1:WRAP_BITS],
            wrap_now ? low_start : low_next};
    wire [ADDR_W-1:0] step_addr = cur_addr + BEAT_STEP;
    wire [ADDR_W-1:0] next_addr = wrap_ok ? wrap_addr : step_addr;
    // Rev 1.1 constant-mode read with a count of 64 or more: data is marked invalid
    wire read_invalid = const_mode && !dir_wr && !rev2
                        && (total >= WRAP_BYTES);

    // A beat fires when memory is ready and write data is on hand
    assign beat = (state == ST_RUN) && mem_ready_i && ce_i
                  && (!dir_wr || fifo_out_valid);
    wire last = (left <= BEAT_BYTES);

    assign mem_strobe_o = (state == ST_RUN) && (!dir_wr || fifo_out_valid);
    assign mem_req_o = '{addr: cur_addr, we: dir_wr, data: fifo_out_data};

    // ----------------------------------------
    // Burst sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            cur_addr <= RST_WORD;
            left <= RST_CNT;
        end else if (ce_i) begin
            case (state)
                ST_IDLE, ST_DONE: begin
                    if (start) begin
                        state <= (total == RST_CNT) ? ST_DONE : ST_RUN;
                        cur_addr <= base_addr;
                        left <= total;
                    end
                end
                ST_RUN: begin
                    // Step until the count is used up
                    if (beat) begin
                        cur_addr <= next_addr;
                        left <= last ? RST_CNT : left - BEAT_BYTES;
                        if (last) state <= ST_DONE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Status flags: a new burst clears, hardware sets win
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done <= 1'b0;
            wrapped <= 1'b0;
            bad_read <= 1'b0;
            rdata <= RST_WORD;
        end else if (ce_i) begin
            // An empty burst is done at once
            done <= (beat && last) || (start && total == RST_CNT)
                    || (done && !start);
            wrapped <= (beat && wrap_now) || (wrapped && !start);
            // Set from the running config, not the one being replaced
            bad_read <= (beat && read_invalid)
                        || (bad_read && !start);
            if (beat && !dir_wr) begin
                // Invalid read data replaced by zero so it is obvious
                rdata <= read_invalid ? RST_WORD : mem_rdata_i;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_wr <= 1'b0;
            const_mode <= 1'b0;
            rev2 <= 1'b1;
            base_addr <= RST_WORD;
            total <= RST_CNT;
        end else begin
            // Config is locked while a burst runs
            if (wr_ctrl && state != ST_RUN) begin
                dir_wr <= wb_dat_i[CTRL_DIR];
                const_mode <= wb_dat_i[CTRL_MODE];
                rev2 <= wb_dat_i[CTRL_REV2];
            end
            if (wr_addr && state != ST_RUN)
                base_addr <= merge(base_addr, wb_dat_i, wb_sel_i);
            if (wr_count && state != ST_RUN)
                total <= CNT_W'(merge({16'h0000, total}, wb_dat_i, wb_sel_i));
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    // Write data stalls the ack while the FIFO is full
    wire ack_ok = bus_req && ce_i && !(wr_data && !fifo_in_ready);
    wire [DATA_W-1:0] status_word = {28'h0000000, bad_read, wrapped,
            done, state == ST_RUN};
    wire [DATA_W-1:0] ctrl_word = {28'h0000000, rev2, const_mode,
            dir_wr, 1'b0};
    wire [DATA_W-1:0] rd_mux =
        (wb_adr_i == REG_CTRL) ? ctrl_word :
        (wb_adr_i == REG_ADDR) ? base_addr :
        (wb_adr_i == REG_COUNT) ? {16'h0000, total} :
        (wb_adr_i == REG_STATUS) ? status_word :
        (wb_adr_i == REG_CUR) ? cur_addr :
        (wb_adr_i == REG_RDATA) ? rdata : RST_WORD;

    // One-cycle ack, unmapped reads return zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
            wb_dat_o <= RST_WORD;
        end else begin
            ack <= ack_ok;
            if (ack_ok) wb_dat_o <= rd_mux;
            if (!ce_i) ack <= 1'b0;
        end
    end
    assign wb_ack_o = ack;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // A beat whose successor lands back on the window start
    sequence s_beat_wrap;
        beat && wrap_now;
    endsequence
    // A read beat in the old-revision constant case
    sequence s_beat_invalid;
        beat && read_invalid;
    endsequence
    // A burst started with nothing to move
    sequence s_start_empty;
        start && (total == RST_CNT);
    endsequence

    a_write_wrap_window: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_beat_wrap |=> cur_addr == base_addr)
        else $error("wrap did not reload start address");
    a_wrap_flag_set: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_beat_wrap |=> wrapped)
        else $error("wrap not reported in status");
    a_read_rev2_wrap: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) beat && !dir_wr && rev2 && wrap_ok
        |=> cur_addr[ADDR_W-1:WRAP_BITS]
            == $past(cur_addr[ADDR_W-1:WRAP_BITS]))
        else $error("read wrap moved upper bits");
    a_rev1_read_zero: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_beat_invalid |=> rdata == RST_WORD)
        else $error("invalid read passed data");
    a_rev1_read_flag: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_beat_invalid |=> bad_read)
        else $error("invalid read not reported");
    a_short_count_step: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) beat && total < WRAP_BYTES
        |=> cur_addr == $past(cur_addr) + BEAT_STEP)
        else $error("short count did not step");
    a_step_plain: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) beat && !const_mode
        |=> cur_addr == $past(cur_addr) + BEAT_STEP)
        else $error("stepping mode misaddressed");
    a_upper_bits_hold: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) state == ST_RUN && wrap_ok
        |-> cur_addr[ADDR_W-1:WRAP_BITS] == base_addr[ADDR_W-1:WRAP_BITS])
        else $error("upper address bits changed");
    // Empty bursts must not leave software polling forever
    a_empty_burst_done: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) s_start_empty
        |=> done && state == ST_DONE)
        else $error("empty burst did not finish");
    // The acknowledge is a single-cycle pulse
    a_ack_one_cycle: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

// *** eca_mem_model.sv ***
// Behavioural external FIFO chip seen through chip-enable glue logic
`timescale 1ns/1ps
module eca_mem_model
    import eca_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic mem_strobe_i,
    input wire eca_pkg::eca_mem_req_t mem_req_i,
    output logic mem_ready_o,
    output logic [eca_pkg::DATA_W-1:0] mem_rdata_o
);
    // ----------------------------------------------------------------
    // Glue decode: chip selected by address bits 6 and up only
    // ----------------------------------------------------------------
    logic chip_sel; // Low six bits ignored, they wrap inside the window
    logic [DATA_W-1:0] last_word; // Word the chip drove last
    // Window is at least 64 bytes, so constant mode stays legal here
    assign chip_sel = mem_strobe_i
                      && (mem_req_i.addr[31:6] != 26'h0);
    // Data answers this cycle's address; a deselected bus shows the
    // inverse of the last word so stale data cannot pass
    assign mem_rdata_o = chip_sel ? ~mem_req_i.addr : ~last_word;

    // Random stalls and the memory of the last driven word
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ready_o <= 1'b0;
            last_word <= 32'h0;
        end else begin
            mem_ready_o <= ($urandom % 3) != 0;
            if (chip_sel) last_word <= ~mem_req_i.addr;
        end
    end
endmodule

// *** test_eca_port.sv ***
// Self-checking bench for the constant-mode address wrapper
`timescale 1ns/1ps
module test_eca_port;
    import eca_pkg::*;
    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] dat = 32'h0, rd;
    logic [31:0] dat_o;
    logic ack, strobe, ready;
    logic [31:0] rdata;
    eca_mem_req_t req;
    eca_mem_req_t exp_q[$]; // Expected beats, oldest first
    int fail_count = 0, comparisons = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    eca_port uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .mem_req_o(req), .mem_strobe_o(strobe), .mem_ready_i(ready),
        .mem_rdata_i(rdata));
    eca_mem_model far (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .mem_strobe_i(strobe), .mem_req_i(req), .mem_ready_o(ready),
        .mem_rdata_o(rdata));

    // ----------------------------------------------------------------
    // Verdict
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        fail_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    // One classic cycle; the bound stands in for a hung slave
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 400);
        if (n >= 400) begin
            fail("bus answer timed out");
            end_sim();
        end
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) fail($sformatf("read %h expected %h", got, e));
    endtask

    // ----------------------------------------------------------------
    // Beat watcher: every accepted beat takes the oldest note
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_n_i && strobe === 1'b1 && ready === 1'b1) begin
            comparisons++;
            if (exp_q.size() == 0) begin
                fail("beat with nothing expected");
            end else begin
                if (req.addr !== exp_q[0].addr
                    || req.we !== exp_q[0].we
                    || (exp_q[0].we && req.data !== exp_q[0].data))
                    fail($sformatf("beat addr %h", req.addr));
                void'(exp_q.pop_front());
            end
        end
    end

    // Note the beats, program, feed words, wait for done
    task automatic burst(input logic w, input logic m, input logic r2,
                         input logic [31:0] st, input logic [15:0] cnt);
        eca_mem_req_t e;
        logic [31:0] wd[$]; // Write words, kept apart from the beat queue
        logic wrap;
        logic bad;
        int n;
        n = (cnt + 3) / 4;
        wrap = m && (cnt >= 16'd64) && (w || r2);
        bad = !w && m && !r2 && (cnt >= 16'd64);
        e = '0;
        for (int i = 0; i < n; i++) begin
            e.we = w;
            e.data = $urandom;
            e.addr = wrap ? {st[31:6], 6'(st[5:0] + 6'(4 * i))}
                          : st + 32'(4 * i);
            exp_q.push_back(e);
            wd.push_back(e.data);
        end
        wb(1'b1, REG_ADDR, st, rd);
        wb(1'b1, REG_COUNT, {16'h0, cnt}, rd);
        wb(1'b1, REG_CTRL, {28'h0, r2, m, w, 1'b1}, rd);
        for (int i = 0; i < n && w; i++) begin
            wb(1'b1, REG_WDATA, wd[i], rd);
        end
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0, rd);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 300);
        if (rd[STAT_DONE] !== 1'b1) begin
            fail("burst done timed out");
            end_sim();
        end
        chk(rd, {28'h0, bad, wrap, 2'b10});
        if (!w && cnt != 16'h0) begin
            // Last read word: address-tagged, or zero when invalid
            wb(1'b0, REG_RDATA, 32'h0, rd);
            chk(rd, bad ? 32'h0 : ~e.addr);
        end
        comparisons++;
        if (exp_q.size() != 0) fail("beats missing at done");
        $display("test dir=%0d mode=%0d rev2=%0d count=%0d ended", w, m, r2, cnt);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(47));
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wb(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd, 32'h0000_0008);
        wb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b0, 8'h3c, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset values ended");
        burst(1'b1, 1'b1, 1'b1, 32'h1000_0010, 16'd128);
        burst(1'b1, 1'b1, 1'b1, 32'h1000_0040, 16'd64);
        burst(1'b1, 1'b1, 1'b1, 32'h1000_0080, 16'd60);
        burst(1'b1, 1'b0, 1'b1, 32'h2000_0000, 16'd128);
        burst(1'b0, 1'b1, 1'b1, 32'h3000_0020, 16'd96);
        burst(1'b0, 1'b1, 1'b0, 32'h3000_0000, 16'd64);
        burst(1'b0, 1'b0, 1'b1, 32'h3000_0000, 16'd16);
        burst(1'b1, 1'b1, 1'b1, 32'h1000_0000, 16'd0);
        burst(1'b1, 1'b0, 1'b1, 32'h1000_0040, 16'd64);
        burst(1'b1, 1'b0, 1'b1, 32'h1000_0040, 16'd4);
        end_sim();
    end
endmodule
